/* sdram_pkg.sv */
// Shared constants and types for the DRAM row, read and pattern logic
package sdram_pkg;
   localparam int BANKS  = 8;
   localparam int BA_W   = 3;
   localparam int ADDR_W = 16;
   localparam int DQ_W   = 8;
   localparam int BEATS  = 8;
   localparam int COL_W  = 10;
   localparam int AP_BIT = 10;
   localparam int BSEL_BIT = 12;
   // Command codes on the link
   typedef enum logic [2:0] {
      CMD_NOP = 3'h0,
      CMD_ACT = 3'h1,
      CMD_PRE = 3'h2,
      CMD_RD  = 3'h3,
      CMD_RDA = 3'h4,
      CMD_MRS = 3'h5
   } cmd_e;
   // Bank state
   typedef enum logic [1:0] {
      BANK_IDLE   = 2'h0,
      BANK_ACTIVE = 2'h1,
      BANK_PRECHG = 2'h2
   } bank_e;
   // Mode register select on the bank inputs, and field layout
   localparam logic [2:0] MR_ZERO  = 3'h0;
   localparam logic [2:0] MR_ONE   = 3'h1;
   localparam logic [2:0] MR_THREE = 3'h3;
   localparam int BURST_LSB   = 0;
   localparam int LAT_LSB     = 4;
   localparam int PAT_EN_BIT  = 2;
   localparam int PAT_LOC_LSB = 0;
   localparam logic [1:0] BURST_FIXED8 = 2'h0;
   localparam logic [1:0] BURST_OTF    = 2'h1;
   localparam logic [1:0] BURST_CHOP4  = 2'h2;
   localparam logic [1:0] PAT_LOC_PRESET = 2'h0;
   localparam logic [1:0] BURST_RST = 2'h0;
   localparam logic [3:0] CL_RST    = 4'h5;
   localparam logic [3:0] AL_RST    = 4'h0;
   // Timing, in picoseconds and in clocks
   localparam int CLK_PS       = 50000;
   localparam int PRECHARGE_PS = 15000;
   localparam int RTP_PS       = 7500;
   localparam int RTP_MIN_CK   = 4;
   localparam int COL_GAP_CK   = 4;
   localparam int PRE_CEIL = (PRECHARGE_PS + CLK_PS - 1) / CLK_PS;
   localparam int RTP_CEIL = (RTP_PS + CLK_PS - 1) / CLK_PS;
   localparam int PRE_CK = (PRE_CEIL < 1) ? 1 : PRE_CEIL;
   localparam int RTP_CK = (RTP_CEIL < RTP_MIN_CK) ? RTP_MIN_CK : RTP_CEIL;
   // Device error flag bits
   localparam int ERR_W        = 5;
   localparam int ERR_ACT_OPEN = 0;
   localparam int ERR_ACT_EARLY = 1;
   localparam int ERR_RD_IDLE  = 2;
   localparam int ERR_COL_GAP  = 3;
   localparam int ERR_PAT_CMD  = 4;
   // Controller register indices and fields
   localparam logic [3:0] REG_CMD     = 4'h0;
   localparam logic [3:0] REG_STATUS  = 4'h1;
   localparam logic [3:0] REG_DATA_LO = 4'h2;
   localparam logic [3:0] REG_DATA_HI = 4'h3;
   localparam int CMD_OP_LSB   = 0;
   localparam int CMD_BA_LSB   = 3;
   localparam int CMD_ADDR_LSB = 6;
   localparam int ST_BUSY    = 0;
   localparam int ST_REFUSED = 1;
   localparam int ST_READY   = 2;
   localparam int ST_PATTERN = 3;
endpackage

/* sdram_link_if.sv */
// Command and read data link between controller and DRAM
`timescale 1ns/1ns
interface sdram_link_if;
   sdram_pkg::cmd_e                   cmd;
   logic [sdram_pkg::BA_W-1:0]        ba;
   logic [sdram_pkg::ADDR_W-1:0]      addr;
   logic [sdram_pkg::DQ_W-1:0]        dq_rise;
   logic [sdram_pkg::DQ_W-1:0]        dq_fall;
   logic                              dq_valid;
   modport ctrl (output cmd, output ba, output addr,
                 input dq_rise, input dq_fall, input dq_valid);
   modport dram (input cmd, input ba, input addr,
                 output dq_rise, output dq_fall, output dq_valid);
endinterface

/* burst_shifter.sv */
// Emits a loaded burst as two beats per clock
`timescale 1ns/1ns
module burst_shifter #(
   parameter int W = 8
) (
   input  wire logic           clk,
   input  wire logic           sys_rst,
   input  wire logic           load,
   input  wire logic           chop,
   input  wire logic [8*W-1:0] word,
   output logic [W-1:0]        dq_rise,
   output logic [W-1:0]        dq_fall,
   output logic                dq_valid
);
   logic [6*W-1:0] rest_reg;
   logic [1:0]     left_reg;

   // Beat pair per clock, two clocks chopped, four otherwise
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         rest_reg <= '0;
         left_reg <= 2'h0;
         dq_rise  <= '0;
         dq_fall  <= '0;
         dq_valid <= 1'b0;
      end else if (load) begin
         dq_rise  <= word[W-1:0];
         dq_fall  <= word[2*W-1:W];
         dq_valid <= 1'b1;
         rest_reg <= word[8*W-1:2*W];
         left_reg <= chop ? 2'h1 : 2'h3;
      end else if (left_reg != 2'h0) begin
         dq_rise  <= rest_reg[W-1:0];
         dq_fall  <= rest_reg[2*W-1:W];
         dq_valid <= 1'b1;
         rest_reg <= {{2*W{1'b0}}, rest_reg[6*W-1:2*W]};
         left_reg <= left_reg - 2'h1;
      end else begin
         dq_valid <= 1'b0;
      end
   end
endmodule // burst_shifter

/* sdram_device.sv */
// DRAM end: bank state, mode registers, read latency and pattern readout
`timescale 1ns/1ns
module sdram_device #(
   parameter int RL_MAX = 32
) (
   input  wire logic                       clk,
   input  wire logic                       sys_rst,
   sdram_link_if.dram                      link,
   output logic [sdram_pkg::ERR_W-1:0]     cmd_err,
   output logic [sdram_pkg::BANKS-1:0]     open_banks,
   output logic                            pattern_mode
);
   localparam int W = sdram_pkg::DQ_W;
   localparam int NB = sdram_pkg::BANKS;
   localparam logic [7:0] PRE_LOAD = 8'(sdram_pkg::PRE_CK - 1);
   localparam logic [7:0] RTP_LOAD = 8'(sdram_pkg::RTP_CK);
   localparam int COL_W_L = sdram_pkg::COL_W;
   localparam int BA_W_L = sdram_pkg::BA_W;

   logic [1:0]                   burst_reg;
   logic [3:0]                   cl_reg;
   logic [3:0]                   al_reg;
   logic                         pat_en_reg;
   logic [1:0]                   pat_loc_reg;
   sdram_pkg::bank_e             bank_reg [NB];
   logic [sdram_pkg::ADDR_W-1:0] row_reg  [NB];
   logic [7:0]                   cnt_reg  [NB];
   logic [1:0]                   gap_reg;
   logic [RL_MAX-1:0]            pv_reg;
   logic [RL_MAX-1:0]            pc_reg;
   logic [8*W-1:0]               pw_reg   [RL_MAX];

   logic                         is_rd;
   logic                         chop;
   logic [COL_W_L-1:0]           col;
   logic [sdram_pkg::ERR_W-1:0]  err;
   logic                         ok;
   logic [8*W-1:0]               word;
   logic [4:0]                   rl;
   logic [4:0]                   tap;
   logic [NB-1:0]                hit;
   sdram_pkg::bank_e             cur;
   logic                         cur_ready;

   // Command decode and burst length choice
   always_comb begin
      is_rd = (link.cmd == sdram_pkg::CMD_RD) || (link.cmd == sdram_pkg::CMD_RDA);
      chop  = (burst_reg == sdram_pkg::BURST_CHOP4) ||
              ((burst_reg == sdram_pkg::BURST_OTF) &&
               !link.addr[sdram_pkg::BSEL_BIT]);
      col   = link.addr[COL_W_L-1:0];
      cur   = bank_reg[link.ba];
      cur_ready = (cur == sdram_pkg::BANK_IDLE) ||
                  ((cur == sdram_pkg::BANK_PRECHG) && (cnt_reg[link.ba] == 8'h0));
   end

   // Legality of the command against bank state and spacing
   always_comb begin
      err = '0;
      if (pat_en_reg) begin
         if (!is_rd && (link.cmd != sdram_pkg::CMD_NOP) &&
             (link.cmd != sdram_pkg::CMD_MRS))
            err[sdram_pkg::ERR_PAT_CMD] = 1'b1;
      end else if (link.cmd == sdram_pkg::CMD_ACT) begin
         if (cur == sdram_pkg::BANK_ACTIVE)
            err[sdram_pkg::ERR_ACT_OPEN] = 1'b1;
         else if (!cur_ready)
            err[sdram_pkg::ERR_ACT_EARLY] = 1'b1;
      end else if (is_rd && (cur != sdram_pkg::BANK_ACTIVE)) begin
         err[sdram_pkg::ERR_RD_IDLE] = 1'b1;
      end
      if (is_rd && (gap_reg != 2'h0))
         err[sdram_pkg::ERR_COL_GAP] = 1'b1;
      ok = (err == '0);
   end

   // Burst word in beat order, pattern or stand-in array contents
   always_comb begin
      logic [2:0] idx;
      logic [W-1:0] beat;
      idx  = 3'h0;
      beat = '0;
      word = '0;
      for (int b = 0; b < sdram_pkg::BEATS; b++) begin
         idx[1:0] = col[1:0] + 2'(b);
         idx[2]   = chop ? col[2] : (col[2] ^ 1'(b >> 2));
         if (pat_en_reg)
            beat = {W{(pat_loc_reg == sdram_pkg::PAT_LOC_PRESET) & idx[0]}};
         else
            beat = row_reg[link.ba][W-1:0] ^ W'({col[COL_W_L-1:3], idx});
         word[b*W +: W] = beat;
      end
   end

   // Mode register writes
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         burst_reg   <= sdram_pkg::BURST_RST;
         cl_reg      <= sdram_pkg::CL_RST;
         al_reg      <= sdram_pkg::AL_RST;
         pat_en_reg  <= 1'b0;
         pat_loc_reg <= sdram_pkg::PAT_LOC_PRESET;
      end else if (ok && (link.cmd == sdram_pkg::CMD_MRS)) begin
         unique case (link.ba)
            sdram_pkg::MR_ZERO: begin
               burst_reg <= link.addr[sdram_pkg::BURST_LSB +: 2];
               cl_reg    <= link.addr[sdram_pkg::LAT_LSB +: 4];
            end
            sdram_pkg::MR_ONE: begin
               al_reg <= link.addr[sdram_pkg::LAT_LSB +: 4];
            end
            sdram_pkg::MR_THREE: begin
               pat_en_reg  <= link.addr[sdram_pkg::PAT_EN_BIT];
               pat_loc_reg <= link.addr[sdram_pkg::PAT_LOC_LSB +: 2];
            end
            default: begin
            end
         endcase
      end
   end

   // Column command spacing counter
   always_ff @(posedge clk) begin
      if (sys_rst)
         gap_reg <= 2'h0;
      else if (ok && is_rd)
         gap_reg <= 2'(sdram_pkg::COL_GAP_CK - 1);
      else if (gap_reg != 2'h0)
         gap_reg <= gap_reg - 2'h1;
   end

   // Per-bank state, row and precharge timer
   genvar i;
   generate
      for (i = 0; i < NB; i++) begin : g_bank
         assign hit[i] = (link.ba == BA_W_L'(i));
         always_ff @(posedge clk) begin
            if (sys_rst) begin
               bank_reg[i] <= sdram_pkg::BANK_IDLE;
               row_reg[i]  <= '0;
               cnt_reg[i]  <= 8'h0;
               open_banks[i] <= 1'b0;
            end else if (ok && (link.cmd == sdram_pkg::CMD_PRE) &&
                         (hit[i] || link.addr[sdram_pkg::AP_BIT])) begin
               bank_reg[i] <= sdram_pkg::BANK_PRECHG;
               cnt_reg[i]  <= PRE_LOAD;
               open_banks[i] <= 1'b0;
            end else if (ok && hit[i] && (link.cmd == sdram_pkg::CMD_ACT)) begin
               bank_reg[i] <= sdram_pkg::BANK_ACTIVE;
               row_reg[i]  <= link.addr;
               open_banks[i] <= 1'b1;
            end else if (ok && hit[i] && !pat_en_reg &&
                         (link.cmd == sdram_pkg::CMD_RDA)) begin
               bank_reg[i] <= sdram_pkg::BANK_PRECHG;
               cnt_reg[i]  <= 8'(al_reg) + RTP_LOAD + PRE_LOAD;
               open_banks[i] <= 1'b0;
            end else if (cnt_reg[i] != 8'h0) begin
               cnt_reg[i] <= cnt_reg[i] - 8'h1;
            end else if (bank_reg[i] == sdram_pkg::BANK_PRECHG) begin
               bank_reg[i] <= sdram_pkg::BANK_IDLE;
            end
         end
      end
   endgenerate

   // Latency pipeline, tapped at read latency minus two
   always_comb begin
      rl  = 5'(al_reg) + 5'(cl_reg);
      tap = (rl < 5'h2) ? 5'h0 : rl - 5'h2;
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         pv_reg <= '0;
         pc_reg <= '0;
      end else begin
         pv_reg <= {pv_reg[RL_MAX-2:0], ok & is_rd};
         pc_reg <= {pc_reg[RL_MAX-2:0], chop};
      end
   end

   always_ff @(posedge clk) begin
      pw_reg[0] <= word;
      for (int k = 1; k < RL_MAX; k++)
         pw_reg[k] <= pw_reg[k-1];
   end

   // Error flags and mode status
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         cmd_err      <= '0;
         pattern_mode <= 1'b0;
      end else begin
         cmd_err      <= err;
         pattern_mode <= pat_en_reg;
      end
   end

   burst_shifter #(
      .W (W)
   ) u_shift (
      .clk      (clk),
      .sys_rst  (sys_rst),
      .load     (pv_reg[tap]),
      .chop     (pc_reg[tap]),
      .word     (pw_reg[tap]),
      .dq_rise  (link.dq_rise),
      .dq_fall  (link.dq_fall),
      .dq_valid (link.dq_valid)
   );
endmodule // sdram_device

/* sdram_controller.sv */
// Controller end: register port, command spacing and read capture
`timescale 1ns/1ns
module sdram_controller (
   input  wire logic        clk,
   input  wire logic        sys_rst,
   sdram_link_if.ctrl       link,
   input  wire logic [3:0]  reg_addr,
   input  wire logic [31:0] reg_wdata,
   input  wire logic        reg_wr,
   input  wire logic        reg_rd,
   output logic [31:0]      reg_rdata
);
   localparam int NB = sdram_pkg::BANKS;
   localparam int W  = sdram_pkg::DQ_W;
   localparam logic [7:0] PRE_LOAD = 8'(sdram_pkg::PRE_CK - 1);
   localparam logic [7:0] RTP_LOAD = 8'(sdram_pkg::RTP_CK - 1);

   logic                          pend_reg;
   sdram_pkg::cmd_e               op_reg;
   logic [2:0]                    ba_reg;
   logic [15:0]                   ad_reg;
   logic                          refused_reg;
   logic                          ready_reg;
   logic                          pat_reg;
   logic [3:0]                    al_reg;
   logic [1:0]                    gap_reg;
   logic [NB-1:0]                 open_reg;
   logic [7:0]                    actw_reg [NB];
   logic [7:0]                    prew_reg [NB];
   logic [8*W-1:0]                data_reg;
   logic                          vld_d_reg;
   logic                          is_rd;
   logic                          go;
   logic                          refuse;
   logic                          pre_free;
   logic [15:0]                   ad_out;

   // Decide whether the pending command may go now or is refused
   always_comb begin
      is_rd    = (op_reg == sdram_pkg::CMD_RD) || (op_reg == sdram_pkg::CMD_RDA);
      pre_free = 1'b1;
      for (int b = 0; b < NB; b++)
         if ((ba_reg == 3'(b) || ad_reg[sdram_pkg::AP_BIT]) && prew_reg[b] != 8'h0)
            pre_free = 1'b0;
      refuse = 1'b0;
      go     = 1'b0;
      ad_out = ad_reg;
      if (is_rd && pat_reg) begin
         ad_out[1:0] = 2'h0;
         ad_out[2]   = ad_reg[2] & !ad_reg[sdram_pkg::BSEL_BIT];
      end
      unique case (op_reg)
         sdram_pkg::CMD_ACT: begin
            refuse = open_reg[ba_reg] || pat_reg;
            go     = !refuse && (actw_reg[ba_reg] == 8'h0);
         end
         sdram_pkg::CMD_PRE: begin
            refuse = pat_reg;
            go     = !refuse && pre_free;
         end
         sdram_pkg::CMD_RD, sdram_pkg::CMD_RDA: begin
            refuse = !pat_reg && !open_reg[ba_reg];
            go     = !refuse && (gap_reg == 2'h0);
         end
         sdram_pkg::CMD_MRS: go = 1'b1;
         default: refuse = 1'b1;
      endcase
      refuse = refuse & pend_reg;
      go     = go & pend_reg;
   end

   // Pending command from the register port
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         pend_reg <= 1'b0;
         op_reg   <= sdram_pkg::CMD_NOP;
         ba_reg   <= 3'h0;
         ad_reg   <= 16'h0;
      end else if (go || refuse) begin
         pend_reg <= 1'b0;
      end else if (reg_wr && reg_addr == sdram_pkg::REG_CMD && !pend_reg) begin
         pend_reg <= 1'b1;
         op_reg   <= sdram_pkg::cmd_e'(reg_wdata[sdram_pkg::CMD_OP_LSB +: 3]);
         ba_reg   <= reg_wdata[sdram_pkg::CMD_BA_LSB +: 3];
         ad_reg   <= reg_wdata[sdram_pkg::CMD_ADDR_LSB +: 16];
      end
   end

   // Link outputs, one command cycle per issue
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         link.cmd  <= sdram_pkg::CMD_NOP;
         link.ba   <= 3'h0;
         link.addr <= 16'h0;
      end else begin
         link.cmd  <= go ? op_reg : sdram_pkg::CMD_NOP;
         link.ba   <= ba_reg;
         link.addr <= ad_out;
      end
   end

   // Shadow of mode state the spacing depends on
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         pat_reg <= 1'b0;
         al_reg  <= sdram_pkg::AL_RST;
      end else if (go && op_reg == sdram_pkg::CMD_MRS) begin
         if (ba_reg == sdram_pkg::MR_THREE)
            pat_reg <= ad_reg[sdram_pkg::PAT_EN_BIT];
         if (ba_reg == sdram_pkg::MR_ONE)
            al_reg <= ad_reg[sdram_pkg::LAT_LSB +: 4];
      end
   end

   // Column spacing and per-bank timers
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         gap_reg  <= 2'h0;
         open_reg <= '0;
         for (int b = 0; b < NB; b++) begin
            actw_reg[b] <= 8'h0;
            prew_reg[b] <= 8'h0;
         end
      end else begin
         gap_reg <= (go && is_rd) ? 2'(sdram_pkg::COL_GAP_CK - 1) :
                    (gap_reg != 2'h0) ? gap_reg - 2'h1 : 2'h0;
         for (int b = 0; b < NB; b++) begin
            if (go && !pat_reg && (ba_reg == 3'(b) || (op_reg == sdram_pkg::CMD_PRE &&
                ad_reg[sdram_pkg::AP_BIT]))) begin
               unique case (op_reg)
                  sdram_pkg::CMD_ACT: open_reg[b] <= 1'b1;
                  sdram_pkg::CMD_PRE: begin
                     open_reg[b] <= 1'b0;
                     actw_reg[b] <= PRE_LOAD;
                  end
                  sdram_pkg::CMD_RD: prew_reg[b] <= 8'(al_reg) + RTP_LOAD;
                  sdram_pkg::CMD_RDA: begin
                     open_reg[b] <= 1'b0;
                     actw_reg[b] <= 8'(al_reg) + RTP_LOAD + PRE_LOAD + 8'h1;
                  end
                  default: begin
                  end
               endcase
            end else begin
               if (actw_reg[b] != 8'h0)
                  actw_reg[b] <= actw_reg[b] - 8'h1;
               if (prew_reg[b] != 8'h0)
                  prew_reg[b] <= prew_reg[b] - 8'h1;
            end
         end
      end
   end

   // Read capture; a burst end beats a clearing read
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         data_reg    <= '0;
         vld_d_reg   <= 1'b0;
         ready_reg   <= 1'b0;
         refused_reg <= 1'b0;
      end else begin
         vld_d_reg <= link.dq_valid;
         if (link.dq_valid)
            data_reg <= {link.dq_fall, link.dq_rise, data_reg[8*W-1:2*W]};
         if (vld_d_reg && !link.dq_valid)
            ready_reg <= 1'b1;
         else if (reg_rd && reg_addr == sdram_pkg::REG_DATA_LO)
            ready_reg <= 1'b0;
         if (refuse)
            refused_reg <= 1'b1;
         else if (reg_wr && reg_addr == sdram_pkg::REG_STATUS)
            refused_reg <= 1'b0;
      end
   end

   // Register read port, data one cycle after the strobe
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         reg_rdata <= 32'h0;
      end else if (reg_rd) begin
         unique case (reg_addr)
            sdram_pkg::REG_STATUS: reg_rdata <= {28'h0, pat_reg, ready_reg,
                                                 refused_reg, pend_reg};
            sdram_pkg::REG_DATA_LO: reg_rdata <= data_reg[31:0];
            sdram_pkg::REG_DATA_HI: reg_rdata <= data_reg[63:32];
            default: reg_rdata <= 32'h0;
         endcase
      end else begin
         reg_rdata <= 32'h0;
      end
   end
endmodule // sdram_controller

/* sdram_row_read_calib_monitor.sv */
// Link checker: command spacing, read latency, bank use and pattern readout
`timescale 1ns/1ns
module sdram_row_read_calib_monitor (
   input wire logic                         clk,
   input wire logic                         sys_rst,
   input wire sdram_pkg::cmd_e              cmd,
   input wire logic [sdram_pkg::BA_W-1:0]   ba,
   input wire logic [sdram_pkg::ADDR_W-1:0] addr,
   input wire logic [sdram_pkg::DQ_W-1:0]   dq_rise,
   input wire logic [sdram_pkg::DQ_W-1:0]   dq_fall,
   input wire logic                         dq_valid
);
   logic [3:0]  cl_reg;
   logic [3:0]  al_reg;
   logic        pat_reg;
   logic [1:0]  loc_reg;
   logic [7:0]  open_reg;
   logic [31:0] rd_pipe_reg;
   logic [2:0]  rba_reg;
   logic [4:0]  rl;
   logic        is_rd;
   // Read decode and current latency
   assign is_rd = (cmd == sdram_pkg::CMD_RD) || (cmd == sdram_pkg::CMD_RDA);
   assign rl = 5'(cl_reg) + 5'(al_reg);
   // Mode register shadow
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         cl_reg  <= sdram_pkg::CL_RST;
         al_reg  <= sdram_pkg::AL_RST;
         pat_reg <= 1'b0;
         loc_reg <= 2'h0;
      end else if (cmd == sdram_pkg::CMD_MRS) begin
         if (ba == sdram_pkg::MR_ZERO) cl_reg <= addr[7:4];
         if (ba == sdram_pkg::MR_ONE) al_reg <= addr[7:4];
         if (ba == sdram_pkg::MR_THREE) pat_reg <= addr[2];
         if (ba == sdram_pkg::MR_THREE) loc_reg <= addr[1:0];
      end
   end
   // Open bank shadow
   always_ff @(posedge clk) begin
      if (sys_rst) open_reg <= 8'h00;
      else if (cmd == sdram_pkg::CMD_ACT) open_reg[ba] <= 1'b1;
      else if (cmd == sdram_pkg::CMD_PRE && addr[sdram_pkg::AP_BIT]) open_reg <= 8'h00;
      else if (cmd == sdram_pkg::CMD_PRE) open_reg[ba] <= 1'b0;
      else if (cmd == sdram_pkg::CMD_RDA && !pat_reg) open_reg[ba] <= 1'b0;
   end
   // History of read commands, bit k set k+1 clocks after a read
   always_ff @(posedge clk) begin
      if (sys_rst) rd_pipe_reg <= 32'h0;
      else rd_pipe_reg <= {rd_pipe_reg[30:0], is_rd};
      if (is_rd) rba_reg <= ba;
   end
   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);
   sequence s_rd;
      is_rd;
   endsequence
   property p_rtp;
      cmd == sdram_pkg::CMD_PRE && (ba == rba_reg || addr[sdram_pkg::AP_BIT]) |->
         rd_pipe_reg[2:0] == 3'h0;
   endproperty
   a_read_latency: assert property (rd_pipe_reg[rl-1] |-> dq_valid)
      else $error("read data late or missing");
   a_valid_cause: assert property ($rose(dq_valid) |-> rd_pipe_reg[rl-1])
      else $error("read data without read at latency");
   a_col_gap: assert property (s_rd |=> !is_rd [*3])
      else $error("column commands closer than four clocks");
   a_rtp_spacing: assert property (p_rtp)
      else $error("precharge too soon after read");
   a_pattern_addr: assert property (pat_reg && is_rd |->
      addr[1:0] == 2'h0 && (!addr[2] || !addr[sdram_pkg::BSEL_BIT]))
      else $error("pattern read with bad low column bits");
   a_pattern_cmds: assert property (pat_reg |-> cmd inside {sdram_pkg::CMD_NOP,
      sdram_pkg::CMD_RD, sdram_pkg::CMD_RDA, sdram_pkg::CMD_MRS})
      else $error("non read command in pattern mode");
   a_pattern_data: assert property (pat_reg && loc_reg == 2'h0 && dq_valid |->
      dq_rise == 8'h00 && dq_fall == 8'hff)
      else $error("pattern beats not alternating");
   a_act_closed: assert property (cmd == sdram_pkg::CMD_ACT |-> !open_reg[ba])
      else $error("activate to open bank");
   a_read_open: assert property (is_rd && !pat_reg |-> open_reg[ba])
      else $error("read to bank with no open row");
   a_beats_pair: assert property ($rose(dq_valid) |-> dq_valid [*2])
      else $error("burst shorter than two clocks");
endmodule // sdram_row_read_calib_monitor

/* sdram_row_read_calib_tb.sv */
// Testbench joining controller and device over the link
`timescale 1ns/1ns
module sdram_row_read_calib_tb;
   logic        clk;
   logic        sys_rst;
   logic [3:0]  reg_addr;
   logic [31:0] reg_wdata;
   logic        reg_wr;
   logic        reg_rd;
   logic [31:0] reg_rdata;
   logic [7:0]  open_banks;
   logic [31:0] rd_val;
   int          fail_count;
   int          checks;
   sdram_link_if link ();
   sdram_controller u_sdram_controller (.clk(clk), .sys_rst(sys_rst), .link(link.ctrl),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata(reg_rdata));
   sdram_device u_sdram_device (.clk(clk), .sys_rst(sys_rst), .link(link.dram),
      .cmd_err(), .open_banks(open_banks), .pattern_mode());
   sdram_row_read_calib_monitor u_sdram_row_read_calib_monitor (.clk(clk), .sys_rst(sys_rst),
      .cmd(link.cmd), .ba(link.ba), .addr(link.addr), .dq_rise(link.dq_rise),
      .dq_fall(link.dq_fall), .dq_valid(link.dq_valid));
   // Clock, 50 ns period
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", checks, fail_count);
      if (fail_count == 0 && checks > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         fail_count++;
         $display("BAD t=%0t got %h exp %h", $time, got, exp);
      end
   endtask
   // Register port cycles
   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      @(posedge clk);
      reg_wr    <= 1'b1;
      reg_addr  <= a;
      reg_wdata <= d;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask
   task automatic rd(input logic [3:0] a);
      @(posedge clk);
      reg_rd   <= 1'b1;
      reg_addr <= a;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1 rd_val = reg_rdata;
   endtask
   // Send a command, poll busy and ready bits
   task automatic issue(input logic [2:0] op, input logic [2:0] ba, input logic [15:0] a,
                        input logic [31:0] want);
      int n;
      n = 0;
      wr(sdram_pkg::REG_CMD, {10'h0, a, ba, op});
      do begin
         rd(sdram_pkg::REG_STATUS);
         n++;
      end while ((rd_val & 32'h5) !== want && n < 200);
      if (n >= 200) begin
         fail_count++;
         report_and_stop();
      end
   endtask
   // Refused flag check, then clear it
   task automatic refused(input logic [31:0] exp);
      rd(sdram_pkg::REG_STATUS);
      chk(rd_val & 32'h2, exp);
      wr(sdram_pkg::REG_STATUS, 32'h0);
   endtask
   task automatic rd_data(input logic [31:0] lo, input logic [31:0] hi, input logic full);
      rd(sdram_pkg::REG_DATA_HI);
      chk(rd_val, hi);
      rd(sdram_pkg::REG_DATA_LO);
      if (full) chk(rd_val, lo);
   endtask
   // Four array beats starting at beat b0
   function automatic logic [31:0] exp4(input logic [7:0] row, input logic [9:0] col,
                                        input int b0, input logic bl8);
      logic [31:0] w;
      logic [2:0]  idx;
      for (int b = 0; b < 4; b++) begin
         idx = {col[2] ^ (bl8 & ((b0 + b) >= 4)), col[1:0] + 2'(b0 + b)};
         w[8*b +: 8] = row ^ 8'({col[9:3], idx});
      end
      return w;
   endfunction
   task automatic t_bl8();
      issue(sdram_pkg::CMD_ACT, 3'h2, 16'h0031, 32'h0);
      chk({24'h0, open_banks}, 32'h4);
      issue(sdram_pkg::CMD_RD, 3'h2, 16'h1008, 32'h4);
      rd_data(exp4(8'h31, 10'h008, 0, 1'b1), exp4(8'h31, 10'h008, 4, 1'b1), 1'b1);
   endtask
   task automatic t_refuse();
      issue(sdram_pkg::CMD_ACT, 3'h2, 16'h0077, 32'h0);
      refused(32'h2);
      issue(sdram_pkg::CMD_RD, 3'h5, 16'h1000, 32'h0);
      refused(32'h2);
      issue(sdram_pkg::CMD_RD, 3'h2, 16'h1008, 32'h4);
      rd_data(exp4(8'h31, 10'h008, 0, 1'b1), exp4(8'h31, 10'h008, 4, 1'b1), 1'b1);
      issue(sdram_pkg::CMD_PRE, 3'h0, 16'h0400, 32'h0);
      chk({24'h0, open_banks}, 32'h0);
      issue(sdram_pkg::CMD_PRE, 3'h3, 16'h0000, 32'h0);
      refused(32'h0);
      issue(sdram_pkg::CMD_ACT, 3'h3, 16'h0012, 32'h0);
      chk({24'h0, open_banks}, 32'h8);
      issue(sdram_pkg::CMD_PRE, 3'h3, 16'h0000, 32'h0);
      chk({24'h0, open_banks}, 32'h0);
   endtask
   // Additive latency four, burst chosen per read
   task automatic t_chop();
      issue(sdram_pkg::CMD_MRS, 3'h1, 16'h0040, 32'h0);
      issue(sdram_pkg::CMD_MRS, 3'h0, 16'h0051, 32'h0);
      issue(sdram_pkg::CMD_ACT, 3'h1, 16'h005a, 32'h0);
      issue(sdram_pkg::CMD_RD, 3'h1, 16'h0004, 32'h4);
      rd_data(32'h0, exp4(8'h5a, 10'h004, 0, 1'b0), 1'b0);
      issue(sdram_pkg::CMD_RD, 3'h1, 16'h1004, 32'h4);
      rd_data(exp4(8'h5a, 10'h004, 0, 1'b1), exp4(8'h5a, 10'h004, 4, 1'b1), 1'b1);
      issue(sdram_pkg::CMD_PRE, 3'h1, 16'h0000, 32'h0);
      issue(sdram_pkg::CMD_MRS, 3'h1, 16'h0000, 32'h0);
   endtask
   task automatic t_pattern();
      issue(sdram_pkg::CMD_MRS, 3'h3, 16'h0004, 32'h0);
      rd(sdram_pkg::REG_STATUS);
      chk(rd_val & 32'h8, 32'h8);
      issue(sdram_pkg::CMD_RD, 3'h0, 16'h1000, 32'h4);
      rd_data(32'hff00ff00, 32'hff00ff00, 1'b1);
      issue(sdram_pkg::CMD_RD, 3'h0, 16'h0000, 32'h4);
      rd_data(32'h0, 32'hff00ff00, 1'b0);
      issue(sdram_pkg::CMD_RD, 3'h0, 16'h0004, 32'h4);
      rd_data(32'h0, 32'hff00ff00, 1'b0);
      issue(sdram_pkg::CMD_ACT, 3'h0, 16'h0001, 32'h0);
      refused(32'h2);
      issue(sdram_pkg::CMD_MRS, 3'h3, 16'h0000, 32'h0);
   endtask
   // Reset, then scenarios
   initial begin
      sys_rst    = 1'b1;
      reg_addr   = 4'h0;
      reg_wdata  = 32'h0;
      reg_wr     = 1'b0;
      reg_rd     = 1'b0;
      fail_count = 0;
      checks     = 0;
      repeat (16) @(posedge clk);
      sys_rst <= 1'b0;
      t_bl8();
      t_refuse();
      t_chop();
      t_pattern();
      report_and_stop();
   end
endmodule // sdram_row_read_calib_tb
